/* include/synth_ctrl_pkg.sv */
// types shared by the synthesizer control logic
// assumes the bit layout header alongside it
package synth_ctrl_pkg;
  // destination latch chosen by the two low bits of a word
  typedef enum logic [1:0] {
    LS_REF  = 2'b00,
    LS_FB   = 2'b01,
    LS_FUNC = 2'b10,
    LS_INIT = 2'b11
  } latch_sel_t;
endpackage : synth_ctrl_pkg

/* include/synth_ctrl_regs.svh */
// bit positions, reset values and timing counts for the synthesizer control latches
// assumes a 100 MHz system clock; included by bare name
`ifndef SYNTH_CTRL_REGS_SVH
`define SYNTH_CTRL_REGS_SVH
`define WORD_W        21
`define SEL_HI        1
`define SEL_LO        0
// reference divider word
`define REF_DIV_HI    15
`define REF_DIV_LO    2
`define TEST_HI       19
`define TEST_LO       16
`define LOCK_PREC_BIT 20
// feedback divider word
`define SWALLOW_HI    6
`define SWALLOW_LO    2
`define MAIN_HI       19
`define MAIN_LO       7
`define GAIN_BIT      20
// function and initialization word
`define CLEAR_BIT     2
`define PD_ARM_BIT    3
`define MON_HI        6
`define MON_LO        4
`define POL_BIT       7
`define FLOAT_BIT     8
`define FL_EN_BIT     9
`define FL_MODE_BIT   11
`define TC_HI         15
`define TC_LO         12
`define PD_SYNC_BIT   19
// only these bits are kept; reserved ones are dropped on load
`define FUNC_MASK     21'h08FBFC
`define FUNC_RESET    21'h000000
// timing, system clock period in ns
`define CLK_NS        10
`define ABL_NS        3
`define ABL_CYC       (((`ABL_NS) + (`CLK_NS) - 1) / (`CLK_NS) < 1 ? 1 : \
                       ((`ABL_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define LOCK_NS       15
`define LOCK_CYC      ((`LOCK_NS) / (`CLK_NS))
`define UNLOCK_NS     25
`define UNLOCK_CYC    (((`UNLOCK_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define LOCK_RUN      3
`endif

/* logic/synth_serial_control_latches.sv */
// serial programming latches, dividers, phase detector and lock detect
// assumes ref and prescaled clocks far slower than clock_in, sampled as pins;
// serial clock is a separate domain, host keeps it still while load strobe is high
`timescale 1ns/1ps
`include "synth_ctrl_regs.svh"
module synth_serial_control_latches #(
  parameter logic [23:0] MON_MAP = 24'hFAC688  // slot i source in bits 3i+2..3i
) (
  // clocks and reset
  input  wire logic clock_in,
  input  wire logic rstn_in,
  input  wire logic serial_clock_in,
  // serial link
  input  wire logic serial_data_in,
  input  wire logic load_strobe_in,
  input  wire logic chip_enable_in,
  // divider clock pins
  input  wire logic ref_clock_in,
  input  wire logic prescaled_clock_in,
  // analog lock open-drain pin
  input  wire logic analog_lock_in,
  output logic      analog_lock_out,
  output logic      analog_lock_oe_n_out,
  // detector and pump
  output logic      pump_up_out,
  output logic      pump_down_out,
  output logic      pump_float_out,
  output logic      pump_gain_boost_out,
  output logic      fastlock_active_out,
  output logic      modulus_ctrl_out,
  // status
  output logic      monitor_output_pin_out,
  output logic      digital_lock_out,
  output logic      powered_down_out,
  output logic      ref_buffer_enable_out
);

  // ---- link domain: shift register, runs in power-down too
  logic [`WORD_W-1:0] shift_q;
  always_ff @(posedge serial_clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_q <= 21'h000000;
    end else begin
      shift_q <= {shift_q[`WORD_W-2:0], serial_data_in};
    end
  end

  // ---- pin synchronisers, two flops each before any logic
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [2:0] sync3_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= {chip_enable_in, analog_lock_in, prescaled_clock_in,
                  ref_clock_in, load_strobe_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q[2:0];
    end
  end
  logic load_evt;
  logic ref_edge;
  logic fb_edge;
  logic ce_s;
  assign load_evt = sync2_q[0] & ~sync3_q[0];
  assign ref_edge = sync2_q[1] & ~sync3_q[1];
  assign fb_edge  = sync2_q[2] & ~sync3_q[2];
  assign ce_s     = sync2_q[4];

  // the word is quasi-static: host stops the serial clock while the strobe is
  // high, and the strobe reaches us two flops late, so the bus has settled
  synth_ctrl_pkg::latch_sel_t sel;
  assign sel = synth_ctrl_pkg::latch_sel_t'(shift_q[`SEL_HI:`SEL_LO]);

  // ---- data latches
  logic [`WORD_W-1:0] ref_word_q;
  logic [`WORD_W-1:0] fb_word_q;
  logic [`WORD_W-1:0] func_q;
  logic               init_seen_q;
  logic               rst_pulse_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_word_q  <= 21'h000000;
      fb_word_q   <= 21'h000000;
      func_q      <= `FUNC_RESET;
      init_seen_q <= 1'b0;
      rst_pulse_q <= 1'b0;
    end else begin
      rst_pulse_q <= 1'b0;
      if (load_evt) begin
        unique case (sel)
          synth_ctrl_pkg::LS_REF: begin
            ref_word_q <= shift_q;
          end
          synth_ctrl_pkg::LS_FB: begin
            fb_word_q <= shift_q;
            if (init_seen_q) begin
              rst_pulse_q <= 1'b1;
              init_seen_q <= 1'b0;
            end
          end
          synth_ctrl_pkg::LS_FUNC: begin
            func_q <= shift_q & `FUNC_MASK;
          end
          synth_ctrl_pkg::LS_INIT: begin
            func_q      <= shift_q & `FUNC_MASK;
            rst_pulse_q <= 1'b1;
            init_seen_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // field views
  logic [13:0] ref_div;
  logic [12:0] main_div;
  logic [4:0]  swallow;
  logic [2:0]  mon_sel;
  logic        pd_arm;
  logic        pd_sync;
  assign ref_div  = ref_word_q[`REF_DIV_HI:`REF_DIV_LO];
  assign main_div = fb_word_q[`MAIN_HI:`MAIN_LO];
  assign swallow  = fb_word_q[`SWALLOW_HI:`SWALLOW_LO];
  assign mon_sel  = func_q[`MON_HI:`MON_LO];
  assign pd_arm   = func_q[`PD_ARM_BIT];
  assign pd_sync  = func_q[`PD_SYNC_BIT];

  // ---- power-down control
  logic prog_pd_q;
  logic pump_event;
  logic fresh_func;
  logic pd_now;
  assign fresh_func = load_evt & sel[1];
  assign pd_now     = ~ce_s | prog_pd_q;
  // programmed power-down is kept as a state so that sync mode can wait for
  // the pump; it drops as soon as the arm bit is written back to zero
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prog_pd_q <= 1'b0;
    end else if (!pd_arm) begin
      prog_pd_q <= 1'b0;
    end else if (!pd_sync) begin
      prog_pd_q <= 1'b1;
    end else if (pump_event) begin
      prog_pd_q <= 1'b1;
    end
  end

  // counters sit at load state under clear, power-down or reset pulse
  logic hold;
  assign hold = func_q[`CLEAR_BIT] | pd_now | rst_pulse_q;

  // ---- reference divider
  logic [13:0] ref_cnt_q;
  logic        ref_tick_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_cnt_q  <= 14'h0000;
      ref_tick_q <= 1'b0;
    end else if (hold) begin
      ref_cnt_q  <= 14'h0000;
      ref_tick_q <= 1'b0;
    end else begin
      ref_tick_q <= 1'b0;
      if (ref_edge) begin
        if (ref_cnt_q <= 14'h0001) begin
          ref_cnt_q  <= ref_div;
          ref_tick_q <= 1'b1;
        end else begin
          ref_cnt_q <= ref_cnt_q - 14'h0001;
        end
      end
    end
  end

  // ---- feedback divider: swallow then main, restarts with reference on release
  logic [12:0] main_cnt_q;
  logic [4:0]  sw_cnt_q;
  logic        fb_tick_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      main_cnt_q <= 13'h0000;
      sw_cnt_q   <= 5'h00;
      fb_tick_q  <= 1'b0;
    end else if (hold) begin
      main_cnt_q <= 13'h0000;
      sw_cnt_q   <= 5'h00;
      fb_tick_q  <= 1'b0;
    end else begin
      fb_tick_q <= 1'b0;
      if (fb_edge) begin
        if (main_cnt_q <= 13'h0001) begin
          main_cnt_q <= main_div;
          sw_cnt_q   <= swallow;
          fb_tick_q  <= 1'b1;
        end else begin
          main_cnt_q <= main_cnt_q - 13'h0001;
          if (sw_cnt_q != 5'h00) begin
            sw_cnt_q <= sw_cnt_q - 5'h01;
          end
        end
      end
    end
  end

  // ---- phase-frequency compare with fixed overlap pulse
  logic       up_q;
  logic       dn_q;
  logic [3:0] abl_q;
  logic [3:0] err_q;
  assign pump_event = up_q & dn_q & (abl_q == 4'(`ABL_CYC - 1));
  // overlap width is counted in clock cycles, so it is never below one cycle
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      up_q  <= 1'b0;
      dn_q  <= 1'b0;
      abl_q <= 4'h0;
    end else if (hold) begin
      up_q  <= 1'b0;
      dn_q  <= 1'b0;
      abl_q <= 4'h0;
    end else if (pump_event) begin
      up_q  <= 1'b0;
      dn_q  <= 1'b0;
      abl_q <= 4'h0;
    end else begin
      up_q  <= up_q | ref_tick_q;
      dn_q  <= dn_q | fb_tick_q;
      abl_q <= (up_q & dn_q) ? abl_q + 4'h1 : 4'h0;
    end
  end

  // phase error in cycles while only one side is up
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      err_q <= 4'h0;
    end else if (hold || pump_event) begin
      err_q <= 4'h0;
    end else if (up_q ^ dn_q) begin
      err_q <= (err_q == 4'hF) ? err_q : err_q + 4'h1;
    end
  end

  // ---- digital lock detect
  logic [1:0] good_q;
  logic       lock_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      good_q <= 2'h0;
      lock_q <= 1'b0;
    end else if (pd_now) begin
      good_q <= 2'h0;
      lock_q <= 1'b0;
    end else if (pump_event) begin
      if (err_q <= 4'(`LOCK_CYC)) begin
        good_q <= (good_q == 2'(`LOCK_RUN - 1)) ? good_q : good_q + 2'h1;
        if (good_q == 2'(`LOCK_RUN - 1)) begin
          lock_q <= 1'b1;
        end
      end else begin
        good_q <= 2'h0;
      end
      if (err_q >= 4'(`UNLOCK_CYC)) begin
        lock_q <= 1'b0;
      end
    end
  end

  // ---- monitor mux, slot mapping set at build time
  logic [7:0] mon_src;
  logic [2:0] mon_pick;
  assign mon_src  = {analog_lock_oe_n_out, sw_cnt_q != 5'h00, 1'b1, fb_tick_q,
                     ref_tick_q, sync2_q[3], lock_q, 1'b0};
  assign mon_pick = MON_MAP[3*mon_sel +: 3];

  // ---- registered outputs
  logic pol;
  assign pol = func_q[`POL_BIT];
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pump_up_out            <= 1'b0;
      pump_down_out          <= 1'b0;
      pump_float_out         <= 1'b1;
      pump_gain_boost_out    <= 1'b0;
      fastlock_active_out    <= 1'b0;
      modulus_ctrl_out       <= 1'b0;
      monitor_output_pin_out <= 1'b0;
      digital_lock_out       <= 1'b0;
      powered_down_out       <= 1'b1;
      ref_buffer_enable_out  <= 1'b0;
      analog_lock_out        <= 1'b0;
      analog_lock_oe_n_out   <= 1'b1;
    end else begin
      // negative slope swaps pump direction
      pump_up_out            <= pol ? up_q : dn_q;
      pump_down_out          <= pol ? dn_q : up_q;
      pump_float_out         <= func_q[`FLOAT_BIT] | hold;
      pump_gain_boost_out    <= fb_word_q[`GAIN_BIT];
      fastlock_active_out    <= func_q[`FL_EN_BIT] & fb_word_q[`GAIN_BIT];
      modulus_ctrl_out       <= sw_cnt_q != 5'h00;
      monitor_output_pin_out <= mon_src[mon_pick];
      digital_lock_out       <= lock_q;
      powered_down_out       <= pd_now;
      ref_buffer_enable_out  <= ~pd_now;
      analog_lock_out        <= 1'b0;
      // pulls low while exactly one pump side is active, released during overlap or power-down
      analog_lock_oe_n_out   <= ~(up_q ^ dn_q) | pd_now;
    end
  end

  // ---- assertions
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  property shift_in_p;
    @(posedge serial_clock_in) disable iff (!rstn_in)
      1'b1 |=> shift_q[`WORD_W-1:1] == $past(shift_q[`WORD_W-2:0]);
  endproperty
  shift_msb_a: assert property (shift_in_p)
    else $error("shift register did not move up by one bit");
  fb_route_a: assert property (load_evt && sel == synth_ctrl_pkg::LS_FB
    |=> fb_word_q == $past(shift_q) && $stable(ref_word_q))
    else $error("feedback word not routed");
  func_mask_a: assert property (load_evt && sel == synth_ctrl_pkg::LS_FUNC
    |=> func_q == ($past(shift_q) & `FUNC_MASK))
    else $error("function word not stored masked");
  clear_hold_a: assert property (func_q[`CLEAR_BIT] [*2]
    |-> ref_cnt_q == 14'h0000 && main_cnt_q == 13'h0000)
    else $error("counters run during clear");
  ce_down_a: assert property (!ce_s |=> powered_down_out)
    else $error("chip enable low did not power down");
  async_pd_a: assert property (fresh_func && shift_q[`PD_ARM_BIT]
    && !shift_q[`PD_SYNC_BIT] |=> ##2 powered_down_out)
    else $error("asynchronous power-down late");
  sync_wait_a: assert property (pd_arm && pd_sync && !prog_pd_q && !pump_event
    |=> !prog_pd_q)
    else $error("synchronous power-down before pump event");
  pd_effects_a: assert property (pd_now
    |=> pump_float_out && !ref_buffer_enable_out && !lock_q)
    else $error("power-down effects missing");
  lock_run_a: assert property ($rose(lock_q)
    |-> $past(good_q) == 2'(`LOCK_RUN - 1))
    else $error("lock set before three good cycles");
  overlap_end_a: assert property (pump_event |=> !(up_q && dn_q))
    else $error("overlap pulse not ended");
  init_pulse_a: assert property (load_evt && sel == synth_ctrl_pkg::LS_INIT
    |=> rst_pulse_q && init_seen_q)
    else $error("init load gave no reset pulse");
  first_fb_a: assert property (load_evt && sel == synth_ctrl_pkg::LS_FB
    && !init_seen_q |=> !rst_pulse_q)
    else $error("later feedback load pulsed reset");

  init_seq_c: cover property (rst_pulse_q ##[1:400] rst_pulse_q);
  locked_c: cover property ($rose(lock_q));
  sync_pd_c: cover property (pd_arm && pd_sync && pump_event ##1 prog_pd_q);
  unlock_c: cover property ($fell(lock_q) && !pd_now);

endmodule : synth_serial_control_latches

/* test/synth_host_model.sv */
// host model that programs the synthesizer over the three-wire serial link
// assumes the testbench calls send and keeps words apart by ten system clock cycles
`timescale 1ns/1ps
module synth_host_model (
  // serial link toward the device
  output logic serial_clock_out,
  output logic serial_data_out,
  output logic load_strobe_out
);
  initial begin
    serial_clock_out = 1'b0;
    serial_data_out  = 1'b0;
    load_strobe_out  = 1'b0;
  end

  // one 21-bit word, msb first, 125 ns link clock that runs only inside the frame
  task automatic send(input logic [20:0] word);
    #3.1;
    for (int i = 20; i >= 0; i--) begin
      serial_data_out = word[i];
      #62.5 serial_clock_out = 1'b1;
      #62.5 serial_clock_out = 1'b0;
    end
    // data no longer valid, so do not leave the last bit looking meaningful
    serial_data_out = ~serial_data_out;
    // clock stays still while the strobe is high and well after it
    #100 load_strobe_out = 1'b1;
    #100 load_strobe_out = 1'b0;
    #100;
  endtask : send
endmodule : synth_host_model

/* test/synth_serial_control_latches_tb.sv */
// self-checking bench for the synthesizer serial control latches
// assumes the host model drives the link; divider pins come from a gated clock here
`timescale 1ns/1ps
module synth_serial_control_latches_tb;
  logic       clock_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic       chip_enable_in = 1'b1;
  logic       div_clock = 1'b0;
  logic       run_div = 1'b0;
  int         div_cnt = 0;
  int         cycles = 0;
  int         miscompares = 0;
  int         cmp_count = 0;
  logic       sclk, sdata, strobe;
  logic       lock_wire, lock_val, lock_oe_n;
  logic       up, down, pfloat, gain, fl_act, modc, mon, dlock, pdown, rbuf;

  always #5 clock_in = ~clock_in;
  // open-drain wire with pull-up
  assign lock_wire = lock_oe_n ? 1'b1 : lock_val;

  synth_host_model synth_host_model_inst (
    .serial_clock_out (sclk),
    .serial_data_out  (sdata),
    .load_strobe_out  (strobe)
  );

  synth_serial_control_latches synth_serial_control_latches_inst (
    .clock_in               (clock_in),
    .rstn_in                (rstn_in),
    .serial_clock_in        (sclk),
    .serial_data_in         (sdata),
    .load_strobe_in         (strobe),
    .chip_enable_in         (chip_enable_in),
    .ref_clock_in           (div_clock),
    .prescaled_clock_in     (div_clock),
    .analog_lock_in         (lock_wire),
    .analog_lock_out        (lock_val),
    .analog_lock_oe_n_out   (lock_oe_n),
    .pump_up_out            (up),
    .pump_down_out          (down),
    .pump_float_out         (pfloat),
    .pump_gain_boost_out    (gain),
    .fastlock_active_out    (fl_act),
    .modulus_ctrl_out       (modc),
    .monitor_output_pin_out (mon),
    .digital_lock_out       (dlock),
    .powered_down_out       (pdown),
    .ref_buffer_enable_out  (rbuf)
  );

  // divider pin clock, in phase on both pins so every tick overlaps into a pump event
  always @(posedge clock_in) begin
    #1;
    if (run_div) begin
      div_cnt = div_cnt + 1;
      if (div_cnt == 10) begin
        div_cnt = 0;
        div_clock = ~div_clock;
      end
    end
  end

  // hang guard, generous against roughly 6000 cycles of traffic
  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      results();
    end
  end

  task automatic check(input string name, input logic seen, input logic exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %s expected %b seen %b", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // send a word and let the latch and derived outputs settle
  task automatic wr(input logic [20:0] word);
    synth_host_model_inst.send(word);
    repeat (10) @(posedge clock_in);
    #1;
  endtask : wr

  task automatic t_reset();
    #1;
    check("float_rst", pfloat, 1'b1);
    check("pdown_rst", pdown, 1'b1);
    check("oe_n_rst", lock_oe_n, 1'b1);
  endtask : t_reset

  // monitor steering and reserved bits; polarity set for a positive slope oscillator
  task automatic t_function();
    wr(21'h0000D2);
    check("pdown", pdown, 1'b0);
    check("rbuf", rbuf, 1'b1);
    check("float", pfloat, 1'b0);
    check("mon_one", mon, 1'b1);
    wr(21'h000082);
    check("mon_zero", mon, 1'b0);
    wr(21'h1704D2);
    check("mon_resv", mon, 1'b1);
    check("float_resv", pfloat, 1'b0);
  endtask : t_function

  // words reach only their own latch; a misrouted word would select monitor slot 0
  task automatic t_routing();
    wr(21'h00000C);
    check("mon_ref", mon, 1'b1);
    wr(21'h100001);
    check("gain_on", gain, 1'b1);
    check("fl_off", fl_act, 1'b0);
    check("mon_fb", mon, 1'b1);
    wr(21'h0002D2);
    check("fl_on", fl_act, 1'b1);
    wr(21'h000001);
    check("gain_off", gain, 1'b0);
    check("fl_gone", fl_act, 1'b0);
    wr(21'h000083);
    check("mon_init", mon, 1'b0);
    wr(21'h0000D2);
    check("mon_func", mon, 1'b1);
  endtask : t_routing

  task automatic t_clear();
    wr(21'h0000D6);
    check("float_clr", pfloat, 1'b1);
    wr(21'h0000D2);
    check("float_run", pfloat, 1'b0);
    wr(21'h0001D2);
    check("float_bit", pfloat, 1'b1);
    wr(21'h000082);
  endtask : t_clear

  // chip enable low overrides, latches still load meanwhile
  task automatic t_chip_enable();
    @(posedge clock_in);
    #1 chip_enable_in = 1'b0;
    repeat (6) @(posedge clock_in);
    #1;
    check("pdown_ce", pdown, 1'b1);
    check("rbuf_ce", rbuf, 1'b0);
    check("float_ce", pfloat, 1'b1);
    check("lock_ce", dlock, 1'b0);
    wr(21'h0000D2);
    check("mon_pd", mon, 1'b1);
    @(posedge clock_in);
    #1 chip_enable_in = 1'b1;
    repeat (6) @(posedge clock_in);
    #1;
    check("pdown_up", pdown, 1'b0);
  endtask : t_chip_enable

  task automatic t_async_pd();
    wr(21'h0000DA);
    check("pdown_arm", pdown, 1'b1);
    check("float_arm", pfloat, 1'b1);
    wr(21'h0000D2);
    check("pdown_off", pdown, 1'b0);
  endtask : t_async_pd

  // equal dividers of three on one pin clock keep every compare in phase, so lock follows
  task automatic t_lock();
    int n;
    wr(21'h000181);
    run_div = 1'b1;
    n = 0;
    while (up !== 1'b1 && n < 100) begin
      @(posedge clock_in);
      #1 n = n + 1;
    end
    check("pump_up", up, 1'b1);
    check("pump_dn", down, 1'b1);
    n = 0;
    while (dlock !== 1'b1 && n < 400) begin
      @(posedge clock_in);
      #1 n = n + 1;
    end
    check("dlock", dlock, 1'b1);
    check("lock_oe_n", lock_oe_n, 1'b1);
    check("lock_val", lock_val, 1'b0);
    run_div = 1'b0;
    // let the last pin edge drain through the synchronisers
    repeat (30) @(posedge clock_in);
    #1;
  endtask : t_lock

  // synchronous mode waits for a pump event, none occurs while the pins are still
  task automatic t_sync_pd();
    int n;
    wr(21'h0800DA);
    check("pdown_wait", pdown, 1'b0);
    run_div = 1'b1;
    n = 0;
    while (pdown !== 1'b1 && n < 400) begin
      @(posedge clock_in);
      #1 n = n + 1;
    end
    check("pdown_sync", pdown, 1'b1);
    run_div = 1'b0;
  endtask : t_sync_pd

  initial begin
    repeat (10) @(posedge clock_in);
    t_reset();
    rstn_in = 1'b1;
    repeat (5) @(posedge clock_in);
    t_function();
    t_routing();
    t_clear();
    t_chip_enable();
    t_async_pd();
    t_lock();
    t_sync_pd();
    results();
  end
endmodule : synth_serial_control_latches_tb
